/* File: rtl/pmebc_consts.vh */
// constants for the processor mode and external bus controller
`ifndef PMEBC_CONSTS_VH
`define PMEBC_CONSTS_VH

// ==================================================
// processor mode codes
`define PMEBC_MODE_SINGLE 2'b00
`define PMEBC_MODE_MEMEXP 2'b01
`define PMEBC_MODE_RSVD 2'b10
`define PMEBC_MODE_MICRO 2'b11

// ==================================================
// proc_mode_reg_a field positions
`define PMEBC_A_MODE_LO 0
`define PMEBC_A_MODE_HI 1
`define PMEBC_A_STROBE 2
`define PMEBC_A_MUX_LO 4
`define PMEBC_A_MUX_HI 5
`define PMEBC_A_UPPER 6
`define PMEBC_A_BCLKDIS 7

// ==================================================
// proc_mode_reg_b field positions
`define PMEBC_B_ROMREG 0
`define PMEBC_B_MID 1
`define PMEBC_B_SETONLY 2
`define PMEBC_B_EXTAREA 3
`define PMEBC_B_GWAIT 7

// ==================================================
// chip_select_ctrl_reg fields: enables low nibble, area wait bits high nibble
`define PMEBC_CSR_EN_LO 0
`define PMEBC_CSR_WAIT_LO 4

// ==================================================
// reset values
`define PMEBC_REGA_RESET 8'h00
`define PMEBC_REGB_RESET 8'h00
`define PMEBC_CSR_RESET 8'h01

// ==================================================
// bus mode field codes
`define PMEBC_MUX_NONE 2'b00
`define PMEBC_MUX_CS2 2'b01
`define PMEBC_MUX_CS1 2'b10
`define PMEBC_MUX_ALL 2'b11

// ==================================================
// memory map
`define PMEBC_SFR_TOP 20'h003ff
`define PMEBC_RAM_BASE 20'h00400
`define PMEBC_RAM_TOP 20'h03fff
`define PMEBC_ROM_BASE 20'hd0000
`define PMEBC_RSV1_LO 20'h04000
`define PMEBC_RSV1_HI 20'h07fff
`define PMEBC_RSV2_LO 20'h80000
`define PMEBC_RSV2_HI 20'hcffff
`define PMEBC_CS0_BASE 20'he0000
`define PMEBC_CS1_BASE 20'h40000
`define PMEBC_CS2_BASE 20'h08000

// ==================================================
// timing
`define PMEBC_WAIT_NONE 2'd0
`define PMEBC_WAIT_ONE 2'd1
`define PMEBC_STRAP_SETTLE 2'd3

`endif

/* File: rtl/pmebc_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pmebc_sync
#(
   parameter WIDTH = 1
)
(
   input wire sys_clk,
   input wire rst,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         stage1_reg <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;
endmodule // pmebc_sync
`default_nettype wire

/* File: rtl/pmebc_strobe_enc.v */
// read and write strobe encoder for both strobe styles
`timescale 1ns/1ps
`default_nettype none
module pmebc_strobe_enc
(
   input wire active,
   input wire isWrite,
   input wire isWord,
   input wire addrBit0,
   input wire wideBus,
   input wire strobeStyleSel,
   output reg rdN,
   output reg lowN,
   output reg highN
);
   // separate store strobes only exist on the wide bus
   wire sepStyle = wideBus & strobeStyleSel;

   always @*
   begin
      rdN = 1'b1;
      lowN = 1'b1;
      highN = 1'b1;
      if (active)
      begin
         rdN = isWrite;
         if (sepStyle)
         begin
            lowN = ~(isWrite & (isWord | ~addrBit0));
            highN = ~(isWrite & (isWord | addrBit0));
         end
         else
         begin
            lowN = ~isWrite;
            // upper lane enable is meaningless on the narrow bus, held high
            highN = wideBus ? ~(isWord | addrBit0) : 1'b1;
         end
      end
   end
endmodule // pmebc_strobe_enc
`default_nettype wire

/* File: rtl/pmebc_top.v */
// processor mode selection and external bus controller
// Notes on behaviour
// - mode field write selects mode; 10 ignored
// - boot straps high at reset block internal ROM
// - mode registers writable only when unlocked
// - set-only bit: ones set, zeros ignored
// - rewrite flag forces rom region, extended bits
// - global wait gives one wait everywhere
// - area wait bit zero gives one wait
// - extended bit picks internal versus external ranges
// - bus mode field selects separate or multiplexed
// - narrow multiplexed: data 0-7 carry A0-A7
// - wide multiplexed: data 0-7 carry A1-A8
// - multiplexed devices see only even addresses
// - two bits make address 12, 16, 20 lines
// - address undefined until first external access
// - width pin high narrow, low wide
// - four chip selects, each port or select
// - address/select change only as access demands
// - style bit picks strobe set on wide bus
// - separate strobes: low, high, both lanes
// - combined strobes: upper enable with A0
// - ready low at last fall adds wait
// - hold floats bus, grants; hold, DMA, CPU
`timescale 1ns/1ps
`default_nettype none
`include "pmebc_consts.vh"
module pmebc_top
#(
   parameter BCLK_HALF = 2,
   parameter [19:0] RAM_TOP_EXT = 20'h07fff,
   parameter [19:0] ROM_BASE_EXT = 20'h80000
)
(
   input wire sys_clk,
   input wire rst,
   // straps and pins from outside
   input wire bootModePin,
   input wire flashModePin,
   input wire byteWidthPin,
   input wire readyPinN,
   input wire holdPinN,
   // register writes from the cpu side
   input wire modeWriteUnlockBit,
   input wire cpuRewriteFlag,
   input wire procModeRegAWe,
   input wire [7:0] procModeRegAWdata,
   input wire procModeRegBWe,
   input wire [7:0] procModeRegBWdata,
   input wire chipSelectCtrlRegWe,
   input wire [7:0] chipSelectCtrlRegWdata,
   output wire [7:0] procModeRegA,
   output wire [7:0] procModeRegB,
   output wire [7:0] chipSelectCtrlReg,
   output wire [1:0] procMode,
   output wire internalRomBlocked,
   // cpu and dma requesters
   input wire cpuValid,
   input wire cpuWrite,
   input wire cpuWord,
   input wire [19:0] cpuAddr,
   input wire [15:0] cpuWdata,
   output wire cpuReady,
   input wire dmaValid,
   input wire dmaWrite,
   input wire dmaWord,
   input wire [19:0] dmaAddr,
   input wire [15:0] dmaWdata,
   output wire dmaReady,
   output wire respValid,
   output wire respToDma,
   output wire respErr,
   output wire [15:0] respData,
   // internal memory side
   output wire intAccess,
   output wire [19:0] intAddr,
   input wire [15:0] intRdata,
   // external bus pins
   output wire bclkOut,
   output wire [19:0] addrOut,
   input wire [15:0] dataIn,
   output wire [15:0] dataOut,
   output wire dataLowOeN,
   output wire dataHighOeN,
   output wire [3:0] chipSelN,
   output wire readN,
   output wire lowLaneStoreN,
   output wire highLaneStoreN,
   output wire addrLatch,
   output wire busOeN,
   output wire busGrantN,
   // pin function selects
   output wire midAddrIsPort,
   output wire upperAddrIsPort,
   output wire [3:0] chipSelIsPin
);
   // ==================================================
   // state encodings
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_ADDR = 4'b0010;
   localparam [3:0] ST_ACC = 4'b0100;
   localparam [3:0] ST_HOLD = 4'b1000;

   // ==================================================
   // pin synchronisers
   wire [3:0] pinSync;
   wire [15:0] dataSync;
   pmebc_sync #(.WIDTH(4)) uPinSync
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .asyncIn({bootModePin, flashModePin, byteWidthPin, readyPinN}),
      .syncOut(pinSync)
   );
   pmebc_sync #(.WIDTH(16)) uDataSync
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .asyncIn(dataIn),
      .syncOut(dataSync)
   );
   wire [0:0] holdSyncN;
   pmebc_sync #(.WIDTH(1)) uHoldSync
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .asyncIn(holdPinN),
      .syncOut(holdSyncN)
   );
   wire bootSync = pinSync[3];
   wire flashSync = pinSync[2];
   wire wideBus = ~pinSync[1];
   wire readySync = pinSync[0];

   // ==================================================
   // bus clock divider
   reg [7:0] divCnt_reg;
   reg bclk_reg;
   reg bclkOut_reg;
   reg [7:0] modeA_reg;
   wire halfDone = (divCnt_reg == BCLK_HALF[7:0] - 8'd1);
   wire fallTick = halfDone & bclk_reg;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         divCnt_reg <= 8'd0;
         bclk_reg <= 1'b0;
         bclkOut_reg <= 1'b0;
      end
      else
      begin
         divCnt_reg <= halfDone ? 8'd0 : divCnt_reg + 8'd1;
         if (halfDone)
            bclk_reg <= ~bclk_reg;
         bclkOut_reg <= (halfDone ? ~bclk_reg : bclk_reg) & ~modeA_reg[`PMEBC_A_BCLKDIS];
      end
   end

   // ==================================================
   // mode registers and strap capture
   reg [7:0] modeB_reg;
   reg [7:0] csr_reg;
   reg romBlock_reg;
   reg [1:0] strapCnt_reg;
   reg strapDone_reg;
   reg [7:0] modeA_next;
   reg [7:0] modeB_next;

   always @*
   begin
      modeA_next = modeA_reg;
      modeB_next = modeB_reg;
      if (procModeRegAWe & modeWriteUnlockBit)
      begin
         modeA_next[7:2] = procModeRegAWdata[7:2];
         // the reserved code leaves the running mode alone
         if (procModeRegAWdata[1:0] != `PMEBC_MODE_RSVD)
            modeA_next[1:0] = procModeRegAWdata[1:0];
      end
      if (procModeRegBWe & modeWriteUnlockBit)
      begin
         modeB_next = procModeRegBWdata;
         modeB_next[`PMEBC_B_SETONLY] = modeB_reg[`PMEBC_B_SETONLY] |
            procModeRegBWdata[`PMEBC_B_SETONLY];
      end
      if (cpuRewriteFlag)
      begin
         modeB_next[`PMEBC_B_ROMREG] = 1'b1;
         modeB_next[`PMEBC_B_EXTAREA] = 1'b1;
      end
   end

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         modeA_reg <= `PMEBC_REGA_RESET;
         modeB_reg <= `PMEBC_REGB_RESET;
         csr_reg <= `PMEBC_CSR_RESET;
         romBlock_reg <= 1'b0;
         strapCnt_reg <= 2'd0;
         strapDone_reg <= 1'b0;
      end
      else if (!strapDone_reg)
      begin
         // straps are read only once the synchronisers hold pin levels
         strapCnt_reg <= strapCnt_reg + 2'd1;
         if (strapCnt_reg == `PMEBC_STRAP_SETTLE)
         begin
            strapDone_reg <= 1'b1;
            if (bootSync)
               modeA_reg[1:0] <= `PMEBC_MODE_MICRO;
            romBlock_reg <= bootSync & flashSync;
         end
      end
      else
      begin
         modeA_reg <= modeA_next;
         modeB_reg <= modeB_next;
         if (chipSelectCtrlRegWe)
            csr_reg <= chipSelectCtrlRegWdata;
      end
   end

   wire [1:0] mode = modeA_reg[1:0];
   wire extArea = modeB_reg[`PMEBC_B_EXTAREA];
   wire globalWait = modeB_reg[`PMEBC_B_GWAIT];
   wire [1:0] muxSel = modeA_reg[`PMEBC_A_MUX_HI:`PMEBC_A_MUX_LO];
   wire [3:0] csEnable = csr_reg[`PMEBC_CSR_EN_LO+3:`PMEBC_CSR_EN_LO];
   wire [3:0] areaWaitBit = csr_reg[`PMEBC_CSR_WAIT_LO+3:`PMEBC_CSR_WAIT_LO];
   wire extModes = (mode == `PMEBC_MODE_MEMEXP) | (mode == `PMEBC_MODE_MICRO);

   // ==================================================
   // request arbitration: dma beats cpu, hold beats both
   reg [3:0] state_reg;
   wire anyReq = cpuValid | dmaValid;
   wire take = state_reg[0] & fallTick & holdSyncN[0] & strapDone_reg & anyReq;
   assign dmaReady = take & dmaValid;
   assign cpuReady = take & ~dmaValid;
   wire selWrite = dmaValid ? dmaWrite : cpuWrite;
   wire selWord = dmaValid ? dmaWord : cpuWord;
   wire [19:0] selAddr = dmaValid ? dmaAddr : cpuAddr;
   wire [15:0] selWdata = dmaValid ? dmaWdata : cpuWdata;

   // ==================================================
   // address decode
   wire romAllowed = (mode != `PMEBC_MODE_MICRO) & ~romBlock_reg;
   wire [19:0] ramTop = extArea ? RAM_TOP_EXT : `PMEBC_RAM_TOP;
   wire [19:0] romBase = extArea ? ROM_BASE_EXT : `PMEBC_ROM_BASE;
   wire isSfr = selAddr <= `PMEBC_SFR_TOP;
   wire isRam = (selAddr >= `PMEBC_RAM_BASE) & (selAddr <= ramTop);
   wire isRom = (selAddr >= romBase) & romAllowed;
   wire isInt = isSfr | isRam | isRom;
   wire inRsv = ((selAddr >= `PMEBC_RSV1_LO) & (selAddr <= `PMEBC_RSV1_HI)) |
      ((selAddr >= `PMEBC_RSV2_LO) & (selAddr <= `PMEBC_RSV2_HI));
   wire [1:0] area = (selAddr >= `PMEBC_CS0_BASE) ? 2'd0 :
      (selAddr >= `PMEBC_CS1_BASE) ? 2'd1 :
      (selAddr >= `PMEBC_CS2_BASE) ? 2'd2 : 2'd3;
   wire muxArea = (muxSel == `PMEBC_MUX_ALL) | ((muxSel == `PMEBC_MUX_CS2) & (area == 2'd2)) |
      ((muxSel == `PMEBC_MUX_CS1) & (area == 2'd1));
   // odd bytes and words are unreachable on the multiplexed bus
   wire muxBad = muxArea & (selWord | selAddr[0]);
   wire widthBad = selWord & (~wideBus | selAddr[0]);
   wire selErr = ~isInt & (~extModes | (extArea & inRsv) | muxBad | widthBad);
   wire [1:0] intWait = (isSfr | globalWait) ? `PMEBC_WAIT_ONE : `PMEBC_WAIT_NONE;
   wire [1:0] extWait = (~areaWaitBit[area] | globalWait) ? `PMEBC_WAIT_ONE : `PMEBC_WAIT_NONE;

   // ==================================================
   // per-select output masking
   reg [3:0] csActive_reg;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : gCs
         // a select pin left as a port idles high
         assign chipSelN[gi] = ~(csActive_reg[gi] & csEnable[gi]);
      end
   endgenerate
   assign chipSelIsPin = csEnable;

   // ==================================================
   // bus sequencer
   reg [3:0] state_next;
   reg [19:0] addrOut_reg;
   reg [15:0] dataOut_reg;
   reg lowOe_reg;
   reg highOe_reg;
   reg ale_reg;
   reg strobeOn_reg;
   reg accExt_reg;
   reg accWrite_reg;
   reg accWord_reg;
   reg accMux_reg;
   reg accDma_reg;
   reg [1:0] waitCnt_reg;
   reg [19:0] intAddr_reg;
   reg intAccess_reg;
   reg respValid_reg;
   reg respDma_reg;
   reg respErr_reg;
   reg [15:0] respData_reg;
   reg grant_reg;
   reg rdN_reg;
   reg lowN_reg;
   reg highN_reg;
   wire encRdN;
   wire encLowN;
   wire encHighN;

   pmebc_strobe_enc uStrobe
   (
      .active(strobeOn_reg),
      .isWrite(accWrite_reg),
      .isWord(accWord_reg),
      .addrBit0(addrOut_reg[0]),
      .wideBus(wideBus),
      .strobeStyleSel(modeA_reg[`PMEBC_A_STROBE]),
      .rdN(encRdN),
      .lowN(encLowN),
      .highN(encHighN)
   );

   wire accDone = (waitCnt_reg == `PMEBC_WAIT_NONE) & (~accExt_reg | readySync);

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (fallTick & ~holdSyncN[0])
               state_next = ST_HOLD;
            else if (take & ~selErr)
               state_next = (~isInt & muxArea) ? ST_ADDR : ST_ACC;
         ST_ADDR:
            if (fallTick)
               state_next = ST_ACC;
         ST_ACC:
            if (fallTick & accDone)
               state_next = ST_IDLE;
         ST_HOLD:
            if (fallTick & holdSyncN[0])
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_reg <= ST_IDLE;
         addrOut_reg <= 20'h00000;
         dataOut_reg <= 16'h0000;
         lowOe_reg <= 1'b0;
         highOe_reg <= 1'b0;
         ale_reg <= 1'b0;
         strobeOn_reg <= 1'b0;
         csActive_reg <= 4'h0;
         accExt_reg <= 1'b0;
         accWrite_reg <= 1'b0;
         accWord_reg <= 1'b0;
         accMux_reg <= 1'b0;
         accDma_reg <= 1'b0;
         waitCnt_reg <= `PMEBC_WAIT_NONE;
         intAddr_reg <= 20'h00000;
         intAccess_reg <= 1'b0;
         respValid_reg <= 1'b0;
         respDma_reg <= 1'b0;
         respErr_reg <= 1'b0;
         respData_reg <= 16'h0000;
         grant_reg <= 1'b0;
         rdN_reg <= 1'b1;
         lowN_reg <= 1'b1;
         highN_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         respValid_reg <= 1'b0;
         respErr_reg <= 1'b0;
         rdN_reg <= encRdN;
         lowN_reg <= encLowN;
         highN_reg <= encHighN;
         if (take)
         begin
            respDma_reg <= dmaValid;
            accDma_reg <= dmaValid;
            if (selErr)
            begin
               respValid_reg <= 1'b1;
               respErr_reg <= 1'b1;
            end
            else if (isInt)
            begin
               // internal access: selects rise, address keeps last external value
               csActive_reg <= 4'h0;
               accExt_reg <= 1'b0;
               intAccess_reg <= 1'b1;
               intAddr_reg <= selAddr;
               waitCnt_reg <= intWait;
            end
            else
            begin
               // address pins move only on an external access
               addrOut_reg <= selAddr;
               csActive_reg <= 4'h1 << area;
               accExt_reg <= 1'b1;
               accWrite_reg <= selWrite;
               accWord_reg <= selWord;
               accMux_reg <= muxArea;
               waitCnt_reg <= extWait;
               if (muxArea)
               begin
                  ale_reg <= 1'b1;
                  lowOe_reg <= 1'b1;
                  dataOut_reg <= {8'h00, wideBus ? selAddr[8:1] : selAddr[7:0]};
                  if (selWrite)
                     respData_reg <= selWdata;
               end
               else
               begin
                  strobeOn_reg <= 1'b1;
                  dataOut_reg <= selWdata;
                  lowOe_reg <= selWrite;
                  highOe_reg <= selWrite & wideBus;
               end
            end
         end
         else if (state_reg[1] & fallTick)
         begin
            // address phase over: drop latch strobe, start data phase
            ale_reg <= 1'b0;
            strobeOn_reg <= 1'b1;
            lowOe_reg <= accWrite_reg;
            dataOut_reg <= {8'h00, respData_reg[7:0]};
         end
         else if (state_reg[2] & fallTick)
         begin
            if (waitCnt_reg != `PMEBC_WAIT_NONE)
               waitCnt_reg <= waitCnt_reg - 2'd1;
            else if (accDone)
            begin
               strobeOn_reg <= 1'b0;
               lowOe_reg <= 1'b0;
               highOe_reg <= 1'b0;
               intAccess_reg <= 1'b0;
               respValid_reg <= 1'b1;
               respDma_reg <= accDma_reg;
               respData_reg <= accExt_reg ? dataSync : intRdata;
            end
         end
         else if (state_reg[0] & fallTick & ~holdSyncN[0])
         begin
            grant_reg <= 1'b1;
            csActive_reg <= 4'h0;
         end
         else if (state_reg[3] & fallTick & holdSyncN[0])
            grant_reg <= 1'b0;
      end
   end

   // ==================================================
   // outputs
   assign procModeRegA = modeA_reg;
   assign procModeRegB = modeB_reg;
   assign chipSelectCtrlReg = csr_reg;
   assign procMode = mode;
   assign internalRomBlocked = romBlock_reg;
   assign respValid = respValid_reg;
   assign respToDma = respDma_reg;
   assign respErr = respErr_reg;
   assign respData = respData_reg;
   assign intAccess = intAccess_reg;
   assign intAddr = intAddr_reg;
   assign bclkOut = bclkOut_reg;
   assign addrOut = addrOut_reg;
   assign dataOut = dataOut_reg;
   // upper lanes are never driven on the multiplexed bus
   assign dataLowOeN = ~lowOe_reg | grant_reg;
   assign dataHighOeN = ~highOe_reg | accMux_reg | grant_reg;
   assign readN = rdN_reg;
   assign lowLaneStoreN = lowN_reg;
   assign highLaneStoreN = highN_reg;
   assign addrLatch = ale_reg;
   assign busOeN = grant_reg;
   assign busGrantN = ~grant_reg;
   assign midAddrIsPort = modeB_reg[`PMEBC_B_MID];
   // enabling the top lines while the middle ones are ports is prohibited
   assign upperAddrIsPort = modeA_reg[`PMEBC_A_UPPER] | modeB_reg[`PMEBC_B_MID];
endmodule // pmebc_top
`default_nettype wire

/* File: sim/pmebc_properties.sv */
// concurrent checks on the mode and bus controller ports
`timescale 1ns/1ps
`default_nettype none
module pmebc_properties
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic modeWriteUnlockBit,
   input wire logic cpuRewriteFlag,
   input wire logic procModeRegAWe,
   input wire logic [7:0] procModeRegAWdata,
   input wire logic [7:0] procModeRegA,
   input wire logic [7:0] procModeRegB,
   input wire logic [1:0] procMode,
   input wire logic holdPinN,
   input wire logic readyPinN,
   input wire logic respValid,
   input wire logic [3:0] chipSelN,
   input wire logic readN,
   input wire logic lowLaneStoreN,
   input wire logic highLaneStoreN,
   input wire logic busOeN,
   input wire logic busGrantN
);
   // ==========
   // checks
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   chk_mode_write: assert property (
      procModeRegAWe && modeWriteUnlockBit && procModeRegAWdata[1:0] != 2'h2 |=> procMode == $past(procModeRegAWdata[1:0]))
      else $error("mode write lost");
   chk_mode_reserved: assert property (
      procModeRegAWe && modeWriteUnlockBit && procModeRegAWdata[1:0] == 2'h2 |=> $stable(procMode))
      else $error("reserved mode taken");
   chk_locked_write: assert property (
      procModeRegAWe && !modeWriteUnlockBit |=> $stable(procModeRegA))
      else $error("locked write taken");
   chk_set_only: assert property (
      procModeRegB[2] |=> procModeRegB[2])
      else $error("set-only bit cleared");
   chk_rewrite_force: assert property (
      cpuRewriteFlag [*2] |-> procModeRegB[0] && procModeRegB[3])
      else $error("rewrite bits not forced");
   chk_sep_strobes: assert property (
      procModeRegA[2] && !readN |-> lowLaneStoreN && highLaneStoreN)
      else $error("store during read");
   chk_select_onehot: assert property (
      $onehot0(~chipSelN))
      else $error("two areas selected");
   chk_ready_wait: assert property (
      !readyPinN [*8] |-> !respValid)
      else $error("finished while not ready");
   chk_hold_grant: assert property (
      $fell(holdPinN) |-> ##[1:60] !busGrantN)
      else $error("hold not granted");
   chk_hold_float: assert property (
      !busGrantN [*2] |-> busOeN && &chipSelN)
      else $error("bus driven in hold");
   chk_hold_release: assert property (
      holdPinN [*8] |=> busGrantN)
      else $error("grant without hold");
endmodule // pmebc_properties
bind pmebc_top pmebc_properties chk_u (.*);
`default_nettype wire

/* File: sim/pmebc_ext_mem.sv */
// external memory model with a slow ready option
`timescale 1ns/1ps
`default_nettype none
module pmebc_ext_mem
(
   input wire logic linkClk,
   input wire logic slow,
   input wire logic [19:0] addrOut,
   input wire logic [15:0] dataOut,
   input wire logic [3:0] chipSelN,
   input wire logic readN,
   input wire logic lowLaneStoreN,
   input wire logic highLaneStoreN,
   output logic [15:0] dataIn,
   output logic readyPinN
);
   // ==========
   // storage and strobes
   logic [15:0] mem [0:255];
   logic [3:0] waitCnt;
   wire logic idle = readN && lowLaneStoreN && highLaneStoreN;
   always @(posedge lowLaneStoreN) mem[addrOut[8:1]][7:0] <= dataOut[7:0];
   always @(posedge highLaneStoreN) mem[addrOut[8:1]][15:8] <= dataOut[15:8];
   // released lines show the inverse so a stale value cannot pass
   assign dataIn = (!readN && chipSelN != 4'hf) ? mem[addrOut[8:1]] : ~mem[addrOut[8:1]];
   always @(posedge linkClk) waitCnt <= idle ? 4'h0 : waitCnt + 4'h1;
   // a slow device stalls each strobe for two link clocks
   assign readyPinN = !slow || idle || waitCnt >= 4'h2;
endmodule // pmebc_ext_mem
`default_nettype wire

/* File: sim/pmebc_tb_top.sv */
// self-checking bench for the processor mode and external bus controller
`timescale 1ns/1ps
`default_nettype none
module pmebc_tb_top;
   typedef struct packed {logic k; logic [3:0] c; logic e; logic [19:0] a; logic [15:0] w, x;} pmebc_row_t;
   logic sys_clk, rst, linkClk, slow, bootModePin, flashModePin, byteWidthPin, holdPinN, readyPinN;
   logic modeWriteUnlockBit, cpuRewriteFlag, procModeRegAWe, procModeRegBWe, chipSelectCtrlRegWe;
   logic [7:0] procModeRegAWdata, procModeRegBWdata, chipSelectCtrlRegWdata, procModeRegA, procModeRegB, chipSelectCtrlReg;
   logic cpuValid, cpuWrite, cpuWord, dmaValid, dmaWrite, dmaWord, cpuReady, dmaReady, respValid, respToDma, respErr;
   logic [19:0] cpuAddr, dmaAddr, intAddr, addrOut;
   logic [15:0] cpuWdata, dmaWdata, respData, intRdata, dataIn, dataOut;
   logic [1:0] procMode;
   logic [3:0] chipSelN, chipSelIsPin;
   logic internalRomBlocked, intAccess, bclkOut, dataLowOeN, dataHighOeN, readN, lowLaneStoreN, highLaneStoreN;
   logic addrLatch, busOeN, busGrantN, midAddrIsPort, upperAddrIsPort;
   int n_mismatch, check_count, n;
   pmebc_row_t r;
   // ==========
   // cases: k bus, c {rewrite,unlock,weA,weB} or {-,dma,write,word}
   pmebc_row_t rows [17] = '{'{1, 4'h1, 1, 20'h10002, 0, 0}, '{0, 4'h2, 0, 0, 16'h01, 16'h0000},
      '{0, 4'h6, 0, 0, 16'h04, 16'h0400}, '{0, 4'h6, 0, 0, 16'h05, 16'h0500}, '{0, 4'h6, 0, 0, 16'h06, 16'h0500},
      '{0, 4'h6, 0, 0, 16'h07, 16'h0700}, '{0, 4'h6, 0, 0, 16'h05, 16'h0500}, '{0, 4'h5, 0, 0, 16'h04, 16'h0504},
      '{0, 4'h5, 0, 0, 16'h00, 16'h0504}, '{1, 4'h3, 0, 20'h10002, 16'h1234, 0}, '{1, 4'h6, 0, 20'h10003, 16'hab00, 0},
      '{1, 4'h1, 0, 20'h10002, 0, 16'hab34}, '{1, 4'h6, 0, 20'h10002, 16'h0056, 0}, '{1, 4'h1, 0, 20'h10002, 0, 16'hab56},
      '{1, 4'h1, 1, 20'h10001, 0, 0}, '{1, 4'h1, 0, 20'h00400, 0, 16'h5e5a}, '{0, 4'hd, 0, 0, 16'h00, 16'h050d}};
   assign intRdata = intAddr[15:0] ^ 16'h5a5a;
   pmebc_top dut_u (.*);
   pmebc_ext_mem mem_u (.*);
   initial
   begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial
   begin
      linkClk = 1'h0;
      forever #32 linkClk = ~linkClk;
   end
   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // request held until taken, then wait for the answer
   task automatic bus(input logic dm, w, d, input logic [19:0] a, input logic [15:0] wd);
      if (dm)
         {dmaValid, dmaWrite, dmaWord, dmaAddr, dmaWdata} = {1'h1, w, d, a, wd};
      else
         {cpuValid, cpuWrite, cpuWord, cpuAddr, cpuWdata} = {1'h1, w, d, a, wd};
      for (n = 0; n < 99 && (dm ? dmaReady : cpuReady) !== 1'h1; n++) @(posedge sys_clk);
      @(negedge sys_clk);
      {cpuValid, dmaValid} = 2'h0;
      for (n = 0; n < 400 && respValid !== 1'h1; n++) @(negedge sys_clk);
   endtask
   initial
   begin
      #100000;
      n_mismatch++;
      test_done;
   end
   initial
   begin
      {rst, holdPinN} = 2'h3;
      {bootModePin, flashModePin, byteWidthPin, modeWriteUnlockBit, cpuRewriteFlag, slow} = 6'h0;
      {procModeRegAWe, procModeRegBWe, chipSelectCtrlRegWe, cpuValid, cpuWrite, cpuWord, dmaValid, dmaWrite, dmaWord} = 9'h0;
      {procModeRegAWdata, procModeRegBWdata, chipSelectCtrlRegWdata, cpuAddr, dmaAddr, cpuWdata, dmaWdata} = 96'h0;
      repeat (5) @(negedge sys_clk);
      rst = 1'h0;
      repeat (10) @(negedge sys_clk);
      chk({procModeRegA, procModeRegB, chipSelectCtrlReg, chipSelN, busGrantN}, 29'h3f);
      {chipSelectCtrlRegWe, chipSelectCtrlRegWdata} = 9'h104;
      @(negedge sys_clk);
      chipSelectCtrlRegWe = 1'h0;
      chk(chipSelectCtrlReg, 8'h04);
      foreach (rows[i])
      begin
         r = rows[i];
         @(negedge sys_clk);
         if (r.k)
         begin
            bus(r.c[2], r.c[1], r.c[0], r.a, r.w);
            chk({respValid, respErr, respToDma}, {1'h1, r.e, r.c[2]});
            if (!r.e && !r.c[1])
               chk(respData, r.x);
         end
         else
         begin
            {cpuRewriteFlag, modeWriteUnlockBit, procModeRegAWe, procModeRegBWe} = r.c;
            {procModeRegAWdata, procModeRegBWdata} = {r.w[7:0], r.w[7:0]};
            @(negedge sys_clk);
            {procModeRegAWe, procModeRegBWe} = 2'h0;
            @(negedge sys_clk);
            chk({procModeRegA, procModeRegB}, r.x);
         end
      end
      cpuRewriteFlag = 1'h0;
      slow = 1'h1;
      bus(1'h1, 1'h0, 1'h1, 20'h10002, 16'h0);
      chk({respValid, respErr, respToDma, respData}, 19'h5ab56);
      slow = 1'h0;
      holdPinN = 1'h0;
      for (n = 0; n < 99 && busGrantN !== 1'h0; n++) @(negedge sys_clk);
      @(negedge sys_clk);
      chk({busGrantN, busOeN}, 2'h1);
      holdPinN = 1'h1;
      for (n = 0; n < 99 && busGrantN !== 1'h1; n++) @(negedge sys_clk);
      @(negedge sys_clk);
      chk({busGrantN, busOeN}, 2'h2);
      {rst, bootModePin, flashModePin} = 3'h7;
      repeat (5) @(negedge sys_clk);
      rst = 1'h0;
      repeat (10) @(negedge sys_clk);
      chk({procMode, internalRomBlocked}, 3'h7);
      test_done;
   end
endmodule // pmebc_tb_top
`default_nettype wire
